/* File: inc/srfos_pkg.sv */
// Purpose: shared constants for the sdram refresh and output staging block
// Assumes: 16-bit control word, two memory blocks, 24-bit address, 32-bit data
// Notes:   register offsets are byte addresses on the plain register port
`default_nettype none
package srfos_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFS       = 8'h00;
    localparam logic [7:0]  STAT_OFS       = 8'h04;
    localparam logic [7:0]  BLK_RE_OFS     = 8'h08;
    localparam logic [15:0] CTRL_RST       = 16'h0000;
    localparam logic [1:0]  BLK_RE_RST     = 2'h0;

    // ---------------------------------------------------------------
    // control word fields
    // ---------------------------------------------------------------
    localparam int SYNC_BIT    = 15;
    localparam int RSV_BIT     = 14;
    localparam int NAM_BIT     = 13;
    localparam int COC_BIT     = 12;
    localparam int SREF_BIT    = 11;
    localparam int REFRESH_RECOVERY_TIME_HI     = 10;
    localparam int REFRESH_RECOVERY_TIME_LO     = 9;
    localparam int RC_HI       = 8;
    localparam int RC_LO       = 0;
    localparam int RC_W        = 9;
    localparam int STAT_SELF   = 0;
    localparam int STAT_BUSY   = 1;
    localparam int STAT_PEND   = 2;

    // ---------------------------------------------------------------
    // timing counts in bus clocks
    // ---------------------------------------------------------------
    localparam logic [3:0]  RECOV_00       = 4'h3;
    localparam logic [3:0]  RECOV_01       = 4'h6;
    localparam logic [3:0]  RECOV_1X       = 4'h9;
    localparam int          REF_MULT_SHIFT = 4;
    localparam int          INTV_W         = 14;

    // ---------------------------------------------------------------
    // pin widths and address split
    // ---------------------------------------------------------------
    localparam int ADDR_W  = 24;
    localparam int COL_W   = 12;
    localparam int DATA_W  = 32;
    localparam int DQM_W   = 4;
    localparam int NBLK    = 2;
    localparam int STAGE_W = 1 + NBLK + 3 + DQM_W + ADDR_W + DATA_W + 1;

    // refresh engine states
    typedef enum logic [2:0]
    {
        ST_IDLE      = 3'b000,
        ST_REF       = 3'b001,
        ST_RECOV     = 3'b010,
        ST_SELF_ENT  = 3'b011,
        ST_SELF_HOLD = 3'b100,
        ST_SELF_EXIT = 3'b101
    } srfos_state_t;

    // recovery clocks after an auto-refresh command
    function automatic logic [3:0] srfos_recov(input logic [1:0] refresh_recovery_time);
        logic [3:0] n;
        n = RECOV_00;
        if (refresh_recovery_time[1])
            n = RECOV_1X;
        else if (refresh_recovery_time[0])
            n = RECOV_01;
        return n;
    endfunction : srfos_recov

    // refresh spacing: (count + 1) * 16 bus clocks
    function automatic logic [INTV_W-1:0] srfos_interval(input logic [RC_W-1:0] rc);
        logic [INTV_W-1:0] v;
        v = INTV_W'({5'h0_0, rc} + 14'h0001) << REF_MULT_SHIFT;
        return v;
    endfunction : srfos_interval

endpackage : srfos_pkg
`default_nettype wire

/* File: rtl/srfos_out_stage.sv */
// Purpose: two-stage output shift register for sdram pins
// Assumes: clk_i is the bus clock that also clocks the sdram
// Notes:   edge_sel_i is a board strap or the buffered sdram clock
`timescale 1ns/1ps
`default_nettype none
module srfos_out_stage
#(
    parameter int W = 8
)
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    input  wire logic [W-1:0] rst_val_i,
    input  wire logic         edge_sel_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] rise_ff;
    logic [W-1:0] fall_ff;

    // ---------------------------------------------------------------
    // rising stage then falling stage
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rise_ff <= rst_val_i;
        else
            rise_ff <= d_i;                            // [RULE1]
    end

    // falling stage copies the rising stage half a clock later
    always_ff @(negedge clk_i)
    begin
        if (rst_i)
            fall_ff <= rst_val_i;
        else
            fall_ff <= rise_ff;                        // [RULE1]
    end

    // ---------------------------------------------------------------
    // edge select
    // ---------------------------------------------------------------
    // strap is not synchronised: with the buffered clock on it the old
    // value stays out until that clock rises, which is the extra hold
    assign q_o = edge_sel_i ? rise_ff : fall_ff;       // [RULE2] [RULE3]

    a_stage_follow : assert property (@(posedge clk_i) disable iff (rst_i)
        fall_ff == rise_ff)                            // [RULE1]
        else $error("falling stage did not follow rising stage");

    a_stage_delay : assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i |=> rise_ff == $past(d_i))              // [RULE1]
        else $error("rising stage did not capture input");

endmodule : srfos_out_stage
`default_nettype wire

/* File: rtl/srfos_ctrl.sv */
// Purpose: sdram control word, refresh/self-refresh engine, pin staging
// Assumes: register port on sys_clk_i; sdram side on the bus clock pin
// Notes:   control fields cross to the bus clock domain as one word
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1 - outputs pass rising then falling register stage
// RULE2 - strap high rising edge, low falling edge
// RULE3 - buffered clock on strap extends output hold
// RULE4 - sync bit 15, reset zero means async
// RULE5 - only reset returns controller to async mode
// RULE6 - software writes zero to bit 14
// RULE7 - bit 13 clear multiplexes column address
// RULE8 - bit 12 clear: true clock enable, self-refresh
// RULE9 - bit 12 set: command on cke, no self-refresh
// RULE10 - external mux routes command, own self-refresh
// RULE11 - bit 11 set enters and holds self-refresh
// RULE12 - clearing bit 11 issues self-refresh exit
// RULE13 - self-refresh halts interval counter and refresh
// RULE14 - bits 10-9 give 3, 6, 9 recovery clocks
// RULE15 - one recovery setting serves both blocks
// RULE16 - spacing is (count plus one) times sixteen
// RULE17 - refresh only blocks with enable bit set
// RULE18 - counter restarts from zero after each request
module srfos_ctrl
(
    input  wire logic                             sys_clk_i,
    input  wire logic                             srst_i,
    input  wire logic [7:0]                       addr_i,
    input  wire logic [15:0]                      wdata_i,
    input  wire logic                             wr_stb_i,
    input  wire logic                             rd_stb_i,
    output logic      [15:0]                      rdata_o,
    input  wire logic                             bus_clock_pin_i,
    input  wire logic                             output_edge_select_i,
    input  wire logic [2:0]                       acc_cmd_i,
    input  wire logic [srfos_pkg::NBLK-1:0]       acc_cs_i,
    input  wire logic [srfos_pkg::ADDR_W-1:0]     acc_addr_i,
    input  wire logic                             acc_col_phase_i,
    input  wire logic [srfos_pkg::DQM_W-1:0]      acc_dqm_i,
    input  wire logic [srfos_pkg::DATA_W-1:0]     acc_wdata_i,
    input  wire logic                             acc_wdata_oe_i,
    input  wire logic                             acc_cke_cmd_i,
    output logic                                  refresh_busy_o,
    output logic                                  sdram_clock_enable_pin_o,
    output logic      [srfos_pkg::NBLK-1:0]       sd_cs_n_o,
    output logic                                  sd_ras_n_o,
    output logic                                  sd_cas_n_o,
    output logic                                  sd_we_n_o,
    output logic      [srfos_pkg::DQM_W-1:0]      sd_dqm_o,
    output logic      [srfos_pkg::ADDR_W-1:0]     sd_addr_o,
    output logic      [srfos_pkg::DATA_W-1:0]     sd_wdata_o,
    output logic                                  sd_wdata_oe_o
);
    import srfos_pkg::*;

    // ---------------------------------------------------------------
    // system side: control registers
    // ---------------------------------------------------------------
    logic              sync_ff;
    logic              nam_ff;
    logic              coc_ff;
    logic              sref_ff;
    logic [1:0]        refresh_recovery_time_ff;
    logic [RC_W-1:0]   rc_ff;
    logic [NBLK-1:0]   blk_re_ff;
    logic              dirty_ff;
    logic [16:0]       shadow_ff;
    logic              req_tgl_ff;
    logic              ack_meta_ff;
    logic              ack_sync_ff;
    logic [1:0]        stat_meta_ff;
    logic [1:0]        stat_sync_ff;
    logic              cfg_busy;
    logic              wr_ctrl;
    logic              lnk_ack_ff;
    logic              in_self_ff;

    assign wr_ctrl  = wr_stb_i && (addr_i == CTRL_OFS);
    assign cfg_busy = req_tgl_ff != ack_sync_ff;

    // sync bit can only be set by software; reset is the way back
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
            sync_ff <= CTRL_RST[SYNC_BIT];             // [RULE4]
        else if (wr_ctrl && wdata_i[SYNC_BIT])
            sync_ff <= 1'b1;                           // [RULE5]
    end

    // remaining control fields, reserved bit 14 is not stored
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            nam_ff  <= CTRL_RST[NAM_BIT];
            coc_ff  <= CTRL_RST[COC_BIT];
            sref_ff <= CTRL_RST[SREF_BIT];
            refresh_recovery_time_ff <= CTRL_RST[REFRESH_RECOVERY_TIME_HI:REFRESH_RECOVERY_TIME_LO];
            rc_ff   <= CTRL_RST[RC_HI:RC_LO];
        end
        else if (wr_ctrl)
        begin
            nam_ff  <= wdata_i[NAM_BIT];
            coc_ff  <= wdata_i[COC_BIT];
            sref_ff <= wdata_i[SREF_BIT];
            refresh_recovery_time_ff <= wdata_i[REFRESH_RECOVERY_TIME_HI:REFRESH_RECOVERY_TIME_LO];
            rc_ff   <= wdata_i[RC_HI:RC_LO];
        end
    end

    // per-block refresh enables
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
            blk_re_ff <= BLK_RE_RST;
        else if (wr_stb_i && addr_i == BLK_RE_OFS)
            blk_re_ff <= wdata_i[NBLK-1:0];
    end

    // ---------------------------------------------------------------
    // word crossing: shadow held stable until the link acknowledges
    // ---------------------------------------------------------------
    // a write in the launch cycle keeps dirty set, so it is resent
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            dirty_ff   <= 1'b1;
            shadow_ff  <= 17'h0_0000;
            req_tgl_ff <= 1'b0;
        end
        else
        begin
            if (!cfg_busy && dirty_ff)
            begin
                shadow_ff  <= {blk_re_ff, sync_ff, nam_ff, coc_ff, sref_ff, refresh_recovery_time_ff, rc_ff};
                req_tgl_ff <= ~req_tgl_ff;
            end
            if (wr_stb_i && (addr_i == CTRL_OFS || addr_i == BLK_RE_OFS))
                dirty_ff <= 1'b1;
            else if (!cfg_busy)
                dirty_ff <= 1'b0;
        end
    end

    // acknowledge and status come back through two flops
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            ack_meta_ff  <= 1'b0;
            ack_sync_ff  <= 1'b0;
            stat_meta_ff <= 2'h0;
            stat_sync_ff <= 2'h0;
        end
        else
        begin
            ack_meta_ff  <= lnk_ack_ff;
            ack_sync_ff  <= ack_meta_ff;
            stat_meta_ff <= {refresh_busy_o, in_self_ff};
            stat_sync_ff <= stat_meta_ff;
        end
    end

    // read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
            rdata_o <= 16'h0000;
        else if (rd_stb_i)
        begin
            case (addr_i)
                CTRL_OFS:   rdata_o <= {sync_ff, 1'b0, nam_ff, coc_ff, sref_ff, refresh_recovery_time_ff, rc_ff};
                STAT_OFS:   rdata_o <= {13'h0000, cfg_busy | dirty_ff, stat_sync_ff};
                BLK_RE_OFS: rdata_o <= {14'h0000, blk_re_ff};
                default:    rdata_o <= 16'h0000;
            endcase
        end
        else
            rdata_o <= 16'h0000;
    end

    // ---------------------------------------------------------------
    // link side: reset and config capture on the bus clock
    // ---------------------------------------------------------------
    logic              lrst_meta_ff;
    logic              lrst_ff;
    logic              tgl_meta_ff;
    logic              tgl_sync_ff;
    logic [16:0]       lcfg_ff;
    logic              l_sync;
    logic              l_nam;
    logic              l_coc;
    logic              l_sref;
    logic [1:0]        l_refresh_recovery_time;
    logic [RC_W-1:0]   l_rc;
    logic [NBLK-1:0]   l_re;

    // reset carried across as a level
    always_ff @(posedge bus_clock_pin_i)
    begin
        lrst_meta_ff <= srst_i;
        lrst_ff      <= lrst_meta_ff;
    end

    // shadow is only read after its toggle has been synchronised
    always_ff @(posedge bus_clock_pin_i)
    begin
        if (lrst_ff)
        begin
            tgl_meta_ff <= 1'b0;
            tgl_sync_ff <= 1'b0;
            lnk_ack_ff  <= 1'b0;
            lcfg_ff     <= 17'h0_0000;
        end
        else
        begin
            tgl_meta_ff <= req_tgl_ff;
            tgl_sync_ff <= tgl_meta_ff;
            if (tgl_sync_ff != lnk_ack_ff)
            begin
                lcfg_ff    <= shadow_ff;
                lnk_ack_ff <= tgl_sync_ff;
            end
        end
    end

    assign {l_re, l_sync, l_nam, l_coc, l_sref, l_refresh_recovery_time, l_rc} = lcfg_ff;

    // ---------------------------------------------------------------
    // refresh interval counter
    // ---------------------------------------------------------------
    logic [INTV_W-1:0] ref_cnt_ff;
    logic              ref_pend_ff;
    logic              ref_hit;
    logic              pend_take;
    srfos_state_t      state_ff;
    srfos_state_t      nxt_state;
    logic [3:0]        rec_cnt_ff;

    assign ref_hit   = ref_cnt_ff == srfos_interval(l_rc) - 14'h0001;
    assign pend_take = state_ff == ST_IDLE && ref_pend_ff && nxt_state != ST_SELF_ENT;

    // counter halts while the sdrams refresh themselves
    always_ff @(posedge bus_clock_pin_i)
    begin
        if (lrst_ff || !l_sync)
            ref_cnt_ff <= {INTV_W{1'b0}};
        else if (in_self_ff)
            ref_cnt_ff <= ref_cnt_ff;                  // [RULE13]
        else if (ref_hit)
            ref_cnt_ff <= {INTV_W{1'b0}};              // [RULE18]
        else
            ref_cnt_ff <= ref_cnt_ff + 14'h0001;       // [RULE16]
    end

    // request flag, a new hit wins over taking the old one
    always_ff @(posedge bus_clock_pin_i)
    begin
        if (lrst_ff || !l_sync)
            ref_pend_ff <= 1'b0;
        else if (ref_hit && !in_self_ff)
            ref_pend_ff <= 1'b1;                       // [RULE18]
        else if (pend_take)
            ref_pend_ff <= 1'b0;
    end

    // ---------------------------------------------------------------
    // refresh and self-refresh sequencer
    // ---------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (l_sync && l_sref && !l_coc)
                    nxt_state = ST_SELF_ENT;           // [RULE11] [RULE9]
                else if (l_sync && ref_pend_ff && l_re != '0)
                    nxt_state = ST_REF;                // [RULE17]
            end
            ST_REF:       nxt_state = ST_RECOV;
            ST_RECOV:
            begin
                if (rec_cnt_ff == 4'h1)
                    nxt_state = ST_IDLE;
            end
            ST_SELF_ENT:  nxt_state = ST_SELF_HOLD;
            ST_SELF_HOLD:
            begin
                if (!l_sref)
                    nxt_state = ST_SELF_EXIT;          // [RULE12]
            end
            ST_SELF_EXIT: nxt_state = ST_IDLE;
            default:      nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge bus_clock_pin_i)
    begin
        if (lrst_ff)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // one recovery count for both blocks
    always_ff @(posedge bus_clock_pin_i)
    begin
        if (lrst_ff)
            rec_cnt_ff <= 4'h0;
        else if (state_ff == ST_REF)
            rec_cnt_ff <= srfos_recov(l_refresh_recovery_time);         // [RULE14] [RULE15]
        else if (rec_cnt_ff != 4'h0)
            rec_cnt_ff <= rec_cnt_ff - 4'h1;
    end

    // self-refresh flag and busy flag for the access engine
    always_ff @(posedge bus_clock_pin_i)
    begin
        if (lrst_ff)
        begin
            in_self_ff     <= 1'b0;
            refresh_busy_o <= 1'b0;
        end
        else
        begin
            in_self_ff     <= nxt_state == ST_SELF_ENT || nxt_state == ST_SELF_HOLD;
            refresh_busy_o <= nxt_state != ST_IDLE;
        end
    end

    // ---------------------------------------------------------------
    // pin values ahead of staging
    // ---------------------------------------------------------------
    logic              p_cke;
    logic [NBLK-1:0]   p_cs_n;
    logic [2:0]        p_cmd_n;
    logic [ADDR_W-1:0] p_addr;

    // column mux unless linear addressing is chosen
    always_comb
    begin
        if (l_nam)
            p_addr = acc_addr_i;                       // [RULE7]
        else if (acc_col_phase_i)
            p_addr = {{(ADDR_W-COL_W){1'b0}}, acc_addr_i[COL_W-1:0]};           // [RULE7]
        else
            p_addr = {{(ADDR_W-COL_W){1'b0}}, acc_addr_i[ADDR_W-1:COL_W]};      // [RULE7]
    end

    // commands: ras, cas, we active high before inversion
    always_comb
    begin
        p_cs_n  = ~acc_cs_i;
        p_cmd_n = ~acc_cmd_i;
        if (!l_coc)
            p_cke = !(state_ff == ST_SELF_ENT || state_ff == ST_SELF_HOLD);   // [RULE8]
        else
            p_cke = acc_cke_cmd_i;                     // [RULE9]
        case (state_ff)
            ST_IDLE:
            begin
                if (!l_sync)
                begin
                    p_cs_n  = '1;
                    p_cmd_n = 3'b111;
                end
            end
            ST_REF:
            begin
                p_cs_n  = ~l_re;                       // [RULE17]
                p_cmd_n = 3'b001;
            end
            ST_SELF_ENT:
            begin
                p_cs_n  = '0;                          // [RULE11]
                p_cmd_n = 3'b001;
            end
            default:
            begin
                p_cs_n  = '1;
                p_cmd_n = 3'b111;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // two-stage output register
    // ---------------------------------------------------------------
    logic [STAGE_W-1:0] stage_d;
    logic [STAGE_W-1:0] stage_q;
    logic [STAGE_W-1:0] stage_rst;

    assign stage_d   = {p_cke, p_cs_n, p_cmd_n, acc_dqm_i, p_addr, acc_wdata_i,
                        acc_wdata_oe_i && state_ff == ST_IDLE};
    assign stage_rst = {1'b1, {NBLK{1'b1}}, 3'b111, {(STAGE_W-NBLK-4){1'b0}}};

    srfos_out_stage #(.W(STAGE_W)) u_stage
    (
        .clk_i      (bus_clock_pin_i),
        .rst_i      (lrst_ff),
        .d_i        (stage_d),
        .rst_val_i  (stage_rst),
        .edge_sel_i (output_edge_select_i),
        .q_o        (stage_q)
    );

    assign {sdram_clock_enable_pin_o, sd_cs_n_o, sd_ras_n_o, sd_cas_n_o, sd_we_n_o,
            sd_dqm_o, sd_addr_o, sd_wdata_o, sd_wdata_oe_o} = stage_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_recov3;
        (state_ff == ST_RECOV) [*3] ##1 (state_ff == ST_IDLE);
    endsequence

    a_sync_sticky : assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE5]
        sync_ff |=> sync_ff)
        else $error("sync mode left without reset");

    a_recov_three : assert property (@(posedge bus_clock_pin_i) disable iff (lrst_ff) // [RULE14]
        (state_ff == ST_REF && l_refresh_recovery_time == 2'b00) |=> s_recov3)
        else $error("recovery not three clocks");

    a_coc_no_self : assert property (@(posedge bus_clock_pin_i) disable iff (lrst_ff) // [RULE9]
        (state_ff == ST_IDLE && l_coc) |=> state_ff != ST_SELF_ENT)
        else $error("self-refresh entered with cke command mode");

    a_self_cke_low : assert property (@(posedge bus_clock_pin_i) disable iff (lrst_ff) // [RULE11]
        (state_ff == ST_SELF_HOLD && !l_coc) |-> !p_cke)
        else $error("clock enable high during self-refresh");

    a_count_halt : assert property (@(posedge bus_clock_pin_i) disable iff (lrst_ff) // [RULE13]
        (in_self_ff && $past(in_self_ff) && l_sync) |-> $stable(ref_cnt_ff))
        else $error("interval counter ran in self-refresh");

    a_ref_blocks : assert property (@(posedge bus_clock_pin_i) disable iff (lrst_ff) // [RULE17]
        (state_ff == ST_REF) |-> (p_cs_n == ~l_re && l_re != '0))
        else $error("refresh sent to disabled block");

    a_interval_hit : assert property (@(posedge bus_clock_pin_i) disable iff (lrst_ff) // [RULE16]
        (ref_hit && !in_self_ff && l_sync) |=> (ref_pend_ff && ref_cnt_ff == '0))
        else $error("refresh request or restart missing");

    a_exit_issue : assert property (@(posedge bus_clock_pin_i) disable iff (lrst_ff) // [RULE12]
        (state_ff == ST_SELF_HOLD && !l_sref) |=> (state_ff == ST_SELF_EXIT) ##1 (state_ff == ST_IDLE))
        else $error("self-refresh exit not issued");

endmodule : srfos_ctrl
`default_nettype wire

/* File: testbench/srfos_sdram_model.sv */
// Purpose: sdram seen from its pins: counts refreshes, spacing, cke low
// Assumes: pins change on the rising bus clock, so sampled on the falling
// Notes:   no external address mux here, so cke command use stays idle
`timescale 1ns/1ps
`default_nettype none
module srfos_sdram_model
(
    input  wire logic        clk_i,
    input  wire logic        cke_i,
    input  wire logic [1:0]  cs_n_i,
    input  wire logic        ras_n_i,
    input  wire logic        cas_n_i,
    input  wire logic        we_n_i,
    output logic      [15:0] ref_cnt_o,
    output logic      [15:0] gap_o,
    output logic      [1:0]  cs_o,
    output logic             self_o
);
    logic [15:0] gap_ff = 16'h0000;
    // refresh decode; gap counts bus clocks since the previous one
    always @(negedge clk_i)
    begin
        gap_ff <= gap_ff + 16'h0001;
        self_o <= !cke_i;
        if (cke_i && !ras_n_i && !cas_n_i && we_n_i && cs_n_i != 2'b11)
        begin
            ref_cnt_o <= ref_cnt_o + 16'h0001;
            gap_o     <= gap_ff + 16'h0001;
            gap_ff    <= 16'h0000;
            cs_o      <= cs_n_i;
        end
    end
    initial ref_cnt_o = 16'h0000;
endmodule : srfos_sdram_model
`default_nettype wire

/* File: testbench/srfos_ctrl_bench.sv */
// Purpose: register, refresh and self-refresh checks at the pins
// Assumes: strap tied high, access engine idle (no chip selects)
// Notes:   data lanes of the access side get random traffic only
`timescale 1ns/1ps
`default_nettype none
module srfos_ctrl_bench;
    import srfos_pkg::*;
    logic sys_clk_i = 0, bus_clk = 0, srst_i = 1, wr_stb_i = 0, rd_stb_i = 0;
    logic [7:0] addr_i = 8'h00;
    logic [15:0] wdata_i = 16'h0000, rd_v, rdata_o, w, rc, ref_cnt, gap, n;
    logic [23:0] acc_addr = 24'h00_0000;
    logic [31:0] acc_wdata = 32'h0000_0000;
    logic [31:0] acc_wdata_q, sd_wd;
    logic lane_on = 0;
    logic [3:0] acc_dqm = 4'h0;
    logic acc_col = 0, acc_oe = 0, cke, ras_n, cas_n, we_n, busy, self_v;
    logic [1:0] cs_n, cs_v;
    int seed = 14, miscompares = 0, n_tests = 0;
    always #2.5 sys_clk_i = ~sys_clk_i;
    always #7.5 bus_clk = ~bus_clk;
    // random lane traffic keeps the staging flops moving
    always @(posedge bus_clk)
    begin
        acc_addr <= 24'($random(seed)); acc_wdata <= 32'($random(seed));
        acc_dqm <= 4'($random(seed)); acc_col <= 1'($random(seed)); acc_oe <= 1'($random(seed));
        acc_wdata_q <= acc_wdata;
    end
    // data lanes reach the pins one bus clock later, unchanged
    always @(negedge bus_clk)
    begin
        if (lane_on) chk(sd_wd, acc_wdata_q);
    end
    srfos_ctrl i_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i), .rdata_o(rdata_o),
        .bus_clock_pin_i(bus_clk), .output_edge_select_i(1'b1), .acc_cmd_i(3'h0),
        .acc_cs_i(2'h0), .acc_addr_i(acc_addr), .acc_col_phase_i(acc_col),
        .acc_dqm_i(acc_dqm), .acc_wdata_i(acc_wdata), .acc_wdata_oe_i(acc_oe),
        .acc_cke_cmd_i(1'b1), .refresh_busy_o(busy), .sdram_clock_enable_pin_o(cke),
        .sd_cs_n_o(cs_n), .sd_ras_n_o(ras_n), .sd_cas_n_o(cas_n), .sd_we_n_o(we_n),
        .sd_dqm_o(), .sd_addr_o(), .sd_wdata_o(sd_wd), .sd_wdata_oe_o());
    srfos_sdram_model i_mem (.clk_i(bus_clk), .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(ras_n),
        .cas_n_i(cas_n), .we_n_i(we_n), .ref_cnt_o(ref_cnt), .gap_o(gap), .cs_o(cs_v),
        .self_o(self_v));
    function automatic logic [15:0] exp_gap(input logic [15:0] r);
        return (r + 16'h0001) << REF_MULT_SHIFT;
    endfunction : exp_gap
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk_i); addr_i <= a; wdata_i <= d; wr_stb_i <= 1;
        @(posedge sys_clk_i); wr_stb_i <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge sys_clk_i); addr_i <= a; rd_stb_i <= 1;
        @(posedge sys_clk_i); rd_stb_i <= 0;
        @(negedge sys_clk_i); chk(rdata_o, e);
    endtask : rd
    task automatic wait_ref(input logic [15:0] k);
        for (int i = 0; i < 4000 && ref_cnt < k; i++) @(posedge sys_clk_i);
        chk(16'(ref_cnt >= k), 16'h0001);
    endtask : wait_ref
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    initial
    begin
        #200000 miscompares++;
        results();
    end
    initial
    begin
        repeat (20) @(posedge sys_clk_i); srst_i <= 0;
        rd(CTRL_OFS, CTRL_RST);
        rd(BLK_RE_OFS, 16'h0000); rd(8'h0C, 16'h0000);
        rc = 16'($random(seed) & 3);
        // bit 14 kept clear by software
        w = 16'h8000 | 16'(($random(seed) & 3) << REFRESH_RECOVERY_TIME_LO) | rc;
        wr(CTRL_OFS, w); rd(CTRL_OFS, w);
        wr(CTRL_OFS, w & 16'h7FFF); rd(CTRL_OFS, w);
        lane_on <= 1;
        wr(BLK_RE_OFS, 16'h0001); wait_ref(3);
        chk(gap, exp_gap(rc));
        chk(16'(cs_v), 16'h0002);
        wr(CTRL_OFS, w | 16'h0800); repeat (100) @(posedge sys_clk_i);
        chk(16'(self_v), 16'h0001);
        rd(STAT_OFS, 16'h0003); n = ref_cnt; repeat (400) @(posedge sys_clk_i);
        chk(ref_cnt, n);
        wr(CTRL_OFS, w); repeat (100) @(posedge sys_clk_i);
        chk(16'(self_v), 16'h0000);
        wait_ref(n + 2);
        // linear addressing with cke commands: any self-refresh is external
        wr(CTRL_OFS, w | 16'h3800); repeat (100) @(posedge sys_clk_i);
        chk(16'(self_v), 16'h0000);
        wait_ref(ref_cnt + 16'h0002);
        srst_i <= 1; lane_on <= 0; repeat (20) @(posedge sys_clk_i); srst_i <= 0;
        rd(CTRL_OFS, CTRL_RST);
        results();
    end
endmodule : srfos_ctrl_bench
`default_nettype wire
